// ==== verilog/sesa_regs.vh ====
// register offsets, field positions and reset values of the switch event status block
`ifndef SESA_REGS_VH
`define SESA_REGS_VH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define SESA_OFF_CRC_STAT 12'h000
`define SESA_OFF_MGMT_STAT 12'h004
`define SESA_OFF_MGMT_EN 12'h008
`define SESA_OFF_GLB_STAT 12'h00c
`define SESA_OFF_GLB_MASK 12'h010
`define SESA_OFF_MC_ERR 12'h014
`define SESA_OFF_MC_LIMIT 12'h018

// -----------------------------------------------------------------
// global status field positions
// -----------------------------------------------------------------
`define SESA_GLB_CRC 0
`define SESA_GLB_MGMT 1
`define SESA_GLB_MCLAT 2

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define SESA_RST_MASK 3'h0
`define SESA_RST_MC_LIMIT 16'h0100

// -----------------------------------------------------------------
// axi responses
// -----------------------------------------------------------------
`define SESA_RESP_OKAY 2'h0
`define SESA_RESP_SLVERR 2'h2

`endif

// ==== verilog/sesa_mc_timer.v ====
// per-port multicast latency timer
`timescale 1ns/1ps
module sesa_mc_timer #(
  parameter CNT_W = 16
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // control
  input wire [CNT_W-1:0] limit,
  input wire pending,
  input wire sent,
  input wire errClear,
  // status
  output reg expired,
  output reg blocked
);

  reg [CNT_W-1:0] count;

  always @(posedge mclk)
  begin
    if (rst)
    begin
      count <= {CNT_W{1'b0}};
      expired <= 1'b0;
      blocked <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (!pending || sent || blocked)
        count <= {CNT_W{1'b0}};
      else if (count >= limit)
      begin
        expired <= 1'b1;
        count <= {CNT_W{1'b0}};
      end
      else
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      // a fresh expiry wins over a clear in the same cycle
      if (!pending || sent || blocked || count < limit)
      begin
        if (errClear)
          blocked <= 1'b0;
      end
      else
        blocked <= 1'b1;
    end
  end

endmodule // sesa_mc_timer

// ==== verilog/sesa_event_status.v ====
// switch event status aggregation with axi4-lite register access
// Behaviour
// - a port's crc-failed packet sets that port's packet crc fail flag
// - management summary bit is OR of management status bits gated by enables
// - multicast not sent within latency limit sets the multicast latency flag
// - timed-out port gets no multicast until software clears its error bit
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "sesa_regs.vh"
module sesa_event_status #(
  parameter PORTS = 4,
  parameter MGMT_W = 8,
  parameter CNT_W = 16
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // axi4-lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // events, one bit per port or source, from the same clock domain
  input wire [PORTS-1:0] crcFailPulse,
  input wire [MGMT_W-1:0] mgmtEventPulse,
  input wire [PORTS-1:0] mcPending,
  input wire [PORTS-1:0] mcSent,
  // multicast delivery gate and interrupt
  output reg [PORTS-1:0] mcDeliverEnable,
  output reg irq
);

  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  reg [PORTS-1:0] packet_crc_fail_flag;
  reg [MGMT_W-1:0] mgmtStatus;
  reg [MGMT_W-1:0] mgmtEnable;
  reg multicast_latency_timeout_flag;
  reg [2:0] glbMask;
  reg [CNT_W-1:0] mcLimit;
  reg [11:0] wrAddr;
  reg [31:0] wrData;
  reg [3:0] wrStrb;
  reg haveAddr;
  reg haveData;

  wire [PORTS-1:0] mcExpired;
  wire [PORTS-1:0] mcBlocked;
  wire mgmtSummary;
  wire [2:0] glbStatus;
  wire wrFire;
  wire [31:0] wrOnes;

  // byte enables turned into a bit mask
  function [31:0] strbMask;
    input [3:0] s;
    begin
      strbMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  // shared address decode for reads and writes
  function isReg;
    input [11:0] a;
    input [11:0] off;
    begin
      isReg = (a[11:2] == off[11:2]);
    end
  endfunction

  assign wrFire = haveAddr && haveData && !s_axi_bvalid;
  assign wrOnes = wrData & strbMask(wrStrb);
  assign mgmtSummary = |(mgmtStatus & mgmtEnable);
  assign glbStatus = {multicast_latency_timeout_flag, mgmtSummary, |packet_crc_fail_flag};

  // -----------------------------------------------------------------
  // write decode, shared by the register updates below
  // -----------------------------------------------------------------
  wire [31:0] wrKeep;
  wire wrCrcStat;
  wire wrMgmtStat;
  wire wrMgmtEn;
  wire wrGlbStat;
  wire wrGlbMask;
  wire wrMcErr;
  wire wrMcLimit;
  wire [PORTS-1:0] crcClear;
  wire [MGMT_W-1:0] mgmtClear;

  // a byte lane left out of the strobes keeps its old bits
  assign wrKeep = ~strbMask(wrStrb);
  assign wrCrcStat = wrFire && isReg(wrAddr, `SESA_OFF_CRC_STAT);
  assign wrMgmtStat = wrFire && isReg(wrAddr, `SESA_OFF_MGMT_STAT);
  assign wrMgmtEn = wrFire && isReg(wrAddr, `SESA_OFF_MGMT_EN);
  assign wrGlbStat = wrFire && isReg(wrAddr, `SESA_OFF_GLB_STAT);
  assign wrGlbMask = wrFire && isReg(wrAddr, `SESA_OFF_GLB_MASK);
  assign wrMcErr = wrFire && isReg(wrAddr, `SESA_OFF_MC_ERR);
  assign wrMcLimit = wrFire && isReg(wrAddr, `SESA_OFF_MC_LIMIT);
  // clears use only the strobed lanes, cut to each register's width
  assign crcClear = wrCrcStat ? wrOnes[PORTS-1:0] : {PORTS{1'b0}};
  assign mgmtClear = wrMgmtStat ? wrOnes[MGMT_W-1:0] : {MGMT_W{1'b0}};

  // -----------------------------------------------------------------
  // per-port multicast latency timers
  // -----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PORTS; gi = gi + 1)
    begin : gPort
      sesa_mc_timer #(
        .CNT_W(CNT_W)
      ) uTimer (
        .mclk(mclk),
        .rst(rst),
        .limit(mcLimit),
        .pending(mcPending[gi]),
        .sent(mcSent[gi]),
        .errClear(wrMcErr && wrOnes[gi]),
        .expired(mcExpired[gi]),
        .blocked(mcBlocked[gi])
      );
    end
  endgenerate

  // -----------------------------------------------------------------
  // write channel
  // -----------------------------------------------------------------
  // address and data are latched independently, so either order works
  always @(posedge mclk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SESA_RESP_OKAY;
      haveAddr <= 1'b0;
      haveData <= 1'b0;
      wrAddr <= 12'h000;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        wrAddr <= s_axi_awaddr;
        haveAddr <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
        haveData <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrFire)
      begin
        haveAddr <= 1'b0;
        haveData <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (isReg(wrAddr, `SESA_OFF_CRC_STAT) || isReg(wrAddr, `SESA_OFF_MGMT_STAT)
            || isReg(wrAddr, `SESA_OFF_MGMT_EN) || isReg(wrAddr, `SESA_OFF_GLB_STAT)
            || isReg(wrAddr, `SESA_OFF_GLB_MASK) || isReg(wrAddr, `SESA_OFF_MC_ERR)
            || isReg(wrAddr, `SESA_OFF_MC_LIMIT))
          s_axi_bresp <= `SESA_RESP_OKAY;
        else
          s_axi_bresp <= `SESA_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // control registers
  // -----------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (rst)
    begin
      mgmtEnable <= {MGMT_W{1'b0}};
      glbMask <= `SESA_RST_MASK;
      mcLimit <= `SESA_RST_MC_LIMIT;
    end
    else
    begin
      if (wrMgmtEn)
        mgmtEnable <= (mgmtEnable & wrKeep[MGMT_W-1:0]) | wrOnes[MGMT_W-1:0];
      if (wrGlbMask)
        glbMask <= (glbMask & wrKeep[2:0]) | wrOnes[2:0];
      if (wrMcLimit)
        mcLimit <= (mcLimit & wrKeep[CNT_W-1:0]) | wrOnes[CNT_W-1:0];
    end
  end

  // -----------------------------------------------------------------
  // sticky event flags, write one to clear, set wins over clear
  // -----------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (rst)
    begin
      packet_crc_fail_flag <= {PORTS{1'b0}};
      mgmtStatus <= {MGMT_W{1'b0}};
      multicast_latency_timeout_flag <= 1'b0;
    end
    else
    begin
      packet_crc_fail_flag <= (packet_crc_fail_flag & ~crcClear)
        | crcFailPulse;
      mgmtStatus <= (mgmtStatus & ~mgmtClear)
        | mgmtEventPulse;
      if (|mcExpired)
        multicast_latency_timeout_flag <= 1'b1;
      else if (wrGlbStat && wrOnes[`SESA_GLB_MCLAT])
        multicast_latency_timeout_flag <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // outputs: delivery gate and interrupt, both registered
  // -----------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (rst)
    begin
      mcDeliverEnable <= {PORTS{1'b1}};
      irq <= 1'b0;
    end
    else
    begin
      // the timer's blocked bit already covers the expiry cycle
      mcDeliverEnable <= ~(mcBlocked | mcExpired);
      irq <= |(glbStatus & glbMask);
    end
  end

  // -----------------------------------------------------------------
  // read channel, one read in flight
  // -----------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SESA_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SESA_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (isReg(s_axi_araddr, `SESA_OFF_CRC_STAT))
        s_axi_rdata[PORTS-1:0] <= packet_crc_fail_flag;
      else if (isReg(s_axi_araddr, `SESA_OFF_MGMT_STAT))
        s_axi_rdata[MGMT_W-1:0] <= mgmtStatus;
      else if (isReg(s_axi_araddr, `SESA_OFF_MGMT_EN))
        s_axi_rdata[MGMT_W-1:0] <= mgmtEnable;
      else if (isReg(s_axi_araddr, `SESA_OFF_GLB_STAT))
        s_axi_rdata[2:0] <= glbStatus;
      else if (isReg(s_axi_araddr, `SESA_OFF_GLB_MASK))
        s_axi_rdata[2:0] <= glbMask;
      else if (isReg(s_axi_araddr, `SESA_OFF_MC_ERR))
        s_axi_rdata[PORTS-1:0] <= mcBlocked;
      else if (isReg(s_axi_araddr, `SESA_OFF_MC_LIMIT))
        s_axi_rdata[CNT_W-1:0] <= mcLimit;
      else
        s_axi_rresp <= `SESA_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // sesa_event_status

// ==== test/sesa_event_status_assertions.sv ====
// port assertions for the switch event status block
`timescale 1ns/1ps
module sesa_event_status_assertions #(
  parameter PORTS = 4,
  parameter MGMT_W = 8,
  parameter CNT_W = 16
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // multicast and interrupt
  input wire [PORTS-1:0] mcPending,
  input wire [PORTS-1:0] mcDeliverEnable,
  input wire irq
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);

  // a gate may only close for a port that had a request waiting
  AST_BLOCK_CAUSE: assert property (
    !(|($past(mcDeliverEnable) & ~mcDeliverEnable & ~$past(mcPending, 2))))
    else $error("gate closed with no waiting request");
  // only a completed write may reopen a gate
  AST_STAY_BLOCKED: assert property (
    (s_axi_awready && $past(s_axi_awready)) |=> !(|(~$past(mcDeliverEnable) & mcDeliverEnable)))
    else $error("gate reopened without a write");
  AST_IRQ_STICKY: assert property (
    (irq && s_axi_awready && $past(s_axi_awready)) |=> irq)
    else $error("interrupt dropped without a write");
  AST_B_TIME: assert property (
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_R_TIME: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read data late");
  AST_W_CLOSED: assert property (s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write accepted while response open");
  AST_R_CLOSED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data open");
endmodule // sesa_event_status_assertions

bind sesa_event_status sesa_event_status_assertions #(
  .PORTS(PORTS),
  .MGMT_W(MGMT_W),
  .CNT_W(CNT_W)
) i_chk (
  .mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .mcPending, .mcDeliverEnable, .irq
);

// ==== test/sesa_event_status_test.sv ====
// self-checking bench for the switch event status block
`timescale 1ns/1ps
`include "sesa_regs.vh"
`define CK(n,e,g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module sesa_event_status_test;
  logic mclk = 0, rst = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0, crcFailPulse = 0, mcPending = 0, mcSent = 0;
  logic [7:0] mgmtEventPulse = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] mcDeliverEnable;
  int mismatches = 0, comparisons = 0, cyc = 0, n;
  sesa_event_status i_dut (.*);
  always #4 mclk = ~mclk;
  // ------------------------------------------------
  // bus and event tasks
  // ------------------------------------------------
  task wr(input [11:0] a, input [31:0] d, input [1:0] r = 2'h0, input [3:0] s = 4'hf);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    `CK("bresp", r, s_axi_bresp)
  endtask
  task rd(input [11:0] a, input [31:0] e, input [1:0] r = 2'h0);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    `CK("rdata", e, s_axi_rdata)
    `CK("rresp", r, s_axi_rresp)
  endtask
  task ev(input [3:0] c, input [7:0] m);
    @(posedge mclk);
    crcFailPulse <= c;
    mgmtEventPulse <= m;
    @(posedge mclk);
    crcFailPulse <= 0;
    mgmtEventPulse <= 0;
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task t_reset;
    `CK("deliver", 4'hf, mcDeliverEnable)
    rd(`SESA_OFF_GLB_MASK, 0);
    rd(`SESA_OFF_MC_LIMIT, 32'h100);
    rd(12'h01c, 0, `SESA_RESP_SLVERR);
    wr(12'h01c, 32'hffffffff, `SESA_RESP_SLVERR);
    rd(`SESA_OFF_MC_LIMIT, 32'h100);
    $display("test reset done");
  endtask
  task t_crc;
    ev(4'h5, 0);
    ev(4'h1, 0);
    rd(`SESA_OFF_CRC_STAT, 5);
    rd(`SESA_OFF_GLB_STAT, 1);
    wr(`SESA_OFF_CRC_STAT, 1);
    rd(`SESA_OFF_CRC_STAT, 4);
    wr(`SESA_OFF_CRC_STAT, 4);
    rd(`SESA_OFF_CRC_STAT, 0);
    $display("test crc done");
  endtask
  task t_mgmt;
    wr(`SESA_OFF_MGMT_EN, 2);
    ev(0, 8'h81);
    rd(`SESA_OFF_MGMT_STAT, 8'h81);
    rd(`SESA_OFF_GLB_STAT, 0);
    wr(`SESA_OFF_MGMT_EN, 8'h80);
    rd(`SESA_OFF_GLB_STAT, 2);
    wr(`SESA_OFF_GLB_MASK, 2);
    repeat (3) @(posedge mclk);
    `CK("irq", 1'b1, irq)
    wr(`SESA_OFF_GLB_MASK, 0, `SESA_RESP_OKAY, 4'he);
    rd(`SESA_OFF_GLB_MASK, 2);
    wr(`SESA_OFF_GLB_MASK, 1);
    repeat (3) @(posedge mclk);
    `CK("irq", 1'b0, irq)
    wr(`SESA_OFF_MGMT_STAT, 8'hff);
    rd(`SESA_OFF_GLB_STAT, 0);
    $display("test mgmt done");
  endtask
  task t_mc;
    wr(`SESA_OFF_MC_LIMIT, 4);
    @(posedge mclk);
    mcPending <= 4'h6;
    repeat (2) @(posedge mclk);
    mcSent <= 4'h4;
    mcPending <= 4'h2;
    @(posedge mclk);
    mcSent <= 0;
    repeat (2) @(posedge mclk);
    `CK("deliver early", 4'hf, mcDeliverEnable)
    n = 0;
    while (mcDeliverEnable[1] !== 1'b0 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    `CK("deliver", 4'hd, mcDeliverEnable)
    rd(`SESA_OFF_GLB_STAT, 4);
    rd(`SESA_OFF_MC_ERR, 2);
    mcPending <= 0;
    repeat (3) @(posedge mclk);
    `CK("deliver held", 4'hd, mcDeliverEnable)
    wr(`SESA_OFF_MC_ERR, 2);
    repeat (2) @(posedge mclk);
    `CK("deliver open", 4'hf, mcDeliverEnable)
    wr(`SESA_OFF_GLB_STAT, 4);
    rd(`SESA_OFF_GLB_STAT, 0);
    $display("test multicast done");
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 0;
    t_reset;
    t_crc;
    t_mgmt;
    t_mc;
    final_report;
  end
  // hang guard, well above the fewer than 200 cycles the tests need
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      mismatches++;
      final_report;
    end
  end
endmodule // sesa_event_status_test
